// file: rtl/fbc_ctrl.sv
`timescale 1ns/1ps
module fbc_ctrl #(
  parameter int ADDR_W = fbc_pkg::ADDR_W,
  parameter int DATA_W = fbc_pkg::DATA_W,
  parameter logic [7:0] RP_CYCLES = 8'(fbc_pkg::RP_CYC)
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // Host request port.
  input wire logic REQ_VALID,
  input wire logic [1:0] REQ_OP,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic REQ_LSB,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  input wire logic BYTE_MODE,
  input wire logic WRITE_PROTECT,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [DATA_W-1:0] RSP_RDATA,
  output logic RSP_DONE,
  output logic FLASH_BUSY,
  // Flash pins.
  output logic [ADDR_W-1:0] FL_ADDR,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  output logic FL_RESET_N,
  output logic FL_WP_N,
  output logic FL_BYTE_N,
  input wire logic [DATA_W-1:0] FL_DQ_I,
  output logic [DATA_W-1:0] FL_DQ_O,
  output logic [DATA_W-1:0] FL_DQ_OE,
  input wire logic FL_READY_BUSY_N
);

  localparam logic [7:0] ACC_C = 8'(fbc_pkg::ACC_CYC);
  localparam logic [7:0] CE_C = 8'(fbc_pkg::CE_CYC);
  localparam logic [7:0] WP_C = 8'(fbc_pkg::WP_CYC);
  localparam logic [7:0] SU_C = 8'(fbc_pkg::SETUP_CYC);
  localparam logic [7:0] HO_C = 8'(fbc_pkg::HOLD_CYC);
  localparam logic [7:0] RH_C = 8'(fbc_pkg::RH_CYC);

  fbc_pkg::fbc_state_t state_r, state_nxt;
  logic [1:0] op_r;
  logic standby_r;
  logic tload;
  logic [7:0] tcount;
  logic tdone;
  logic is_write;
  logic wr_nxt;
  logic dq_drive;
  logic [DATA_W-1:0] dq_en_word;
  logic [DATA_W-1:0] wdata_pins;

  fbc_timer #(.W(8)) u_timer (
    .clk(CLK),
    .rst(SYS_RST),
    .load(tload),
    .count(tcount),
    .done(tdone)
  );

  // Command, program and erase sequences are all plain writes to the flash.
  assign is_write = (op_r == fbc_pkg::OP_WRITE);
  // The operation latch is not yet loaded on the accepting edge, so look at the request.
  assign wr_nxt = (state_r == fbc_pkg::FBC_IDLE) ? (REQ_OP == fbc_pkg::OP_WRITE) : is_write;
  // In byte mode pin fifteen is the address LSB and is always driven; pins 14..8 float.
  assign dq_en_word = BYTE_MODE ? {1'b1, 7'h00, {8{dq_drive}}} : {DATA_W{dq_drive}};
  assign wdata_pins = BYTE_MODE ? {REQ_LSB, 7'h00, REQ_WDATA[7:0]} : REQ_WDATA;
  assign dq_drive = wr_nxt && (state_nxt == fbc_pkg::FBC_SETUP ||
                                 state_nxt == fbc_pkg::FBC_STROBE ||
                                 state_nxt == fbc_pkg::FBC_HOLD);

  // A read strobe pays the chip-select access time after standby; a write strobe lasts the write-pulse time.
  always_comb
  begin
    state_nxt = state_r;
    tload = 1'b0;
    tcount = 8'h00;
    case (state_r)
      fbc_pkg::FBC_IDLE:
      begin
        if (REQ_VALID && REQ_OP == fbc_pkg::OP_RESET)
        begin
          state_nxt = fbc_pkg::FBC_RESET;
          tload = 1'b1;
          tcount = RP_CYCLES;
        end
        else if (REQ_VALID)
        begin
          state_nxt = fbc_pkg::FBC_SETUP;
          tload = 1'b1;
          tcount = SU_C;
        end
      end
      fbc_pkg::FBC_SETUP:
        if (tdone)
        begin
          state_nxt = fbc_pkg::FBC_STROBE;
          tload = 1'b1;
          if (is_write)
            tcount = WP_C;
          else if (standby_r)
            tcount = (CE_C > ACC_C) ? CE_C : ACC_C;
          else
            tcount = ACC_C;
        end
      fbc_pkg::FBC_STROBE:
        if (tdone)
        begin
          state_nxt = fbc_pkg::FBC_HOLD;
          tload = 1'b1;
          tcount = HO_C;
        end
      fbc_pkg::FBC_HOLD:
        if (tdone)
          state_nxt = fbc_pkg::FBC_IDLE;
      fbc_pkg::FBC_RESET:
        if (tdone)
        begin
          state_nxt = fbc_pkg::FBC_RECOVER;
          tload = 1'b1;
          tcount = RH_C;
        end
      fbc_pkg::FBC_RECOVER:
        if (tdone)
          state_nxt = fbc_pkg::FBC_IDLE;
      default:
        state_nxt = fbc_pkg::FBC_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_r <= fbc_pkg::FBC_IDLE;
      op_r <= fbc_pkg::OP_READ;
      standby_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == fbc_pkg::FBC_IDLE && REQ_VALID)
        op_r <= REQ_OP;
      if (state_nxt == fbc_pkg::FBC_IDLE || state_nxt == fbc_pkg::FBC_RECOVER)
        standby_r <= 1'b1;
      else if (state_nxt == fbc_pkg::FBC_STROBE)
        standby_r <= 1'b0;
    end
  end

  // Pin drivers: every pin is a flop so no glitch reaches the flash.
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      FL_CE_N <= 1'b1;
      FL_OE_N <= 1'b1;
      FL_WE_N <= 1'b1;
      FL_RESET_N <= 1'b0;
      FL_ADDR <= '0;
      FL_DQ_O <= '0;
      FL_DQ_OE <= '0;
      FL_WP_N <= 1'b0;
      FL_BYTE_N <= 1'b1;
    end
    else
    begin
      FL_WP_N <= ~WRITE_PROTECT;
      FL_BYTE_N <= ~BYTE_MODE;
      FL_RESET_N <= (state_nxt != fbc_pkg::FBC_RESET);
      // Chip select covers setup to hold; standby between accesses.
      FL_CE_N <= !(state_nxt == fbc_pkg::FBC_SETUP || state_nxt == fbc_pkg::FBC_STROBE ||
                   state_nxt == fbc_pkg::FBC_HOLD);
      FL_OE_N <= !(!is_write && state_nxt == fbc_pkg::FBC_STROBE);
      FL_WE_N <= !(is_write && state_nxt == fbc_pkg::FBC_STROBE);
      if (state_r == fbc_pkg::FBC_IDLE && REQ_VALID)
      begin
        FL_ADDR <= REQ_ADDR;
        FL_DQ_O <= wdata_pins;
      end
      FL_DQ_OE <= dq_en_word;
    end
  end

  // Read data is sampled at the end of the output-enable phase.
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= '0;
      RSP_DONE <= 1'b0;
      FLASH_BUSY <= 1'b0;
    end
    else
    begin
      // Reads need no command first; reset clears ready and the port is ready from the first clock after reset.
      REQ_READY <= (state_nxt == fbc_pkg::FBC_IDLE) && !(state_r == fbc_pkg::FBC_IDLE && REQ_VALID);
      RSP_VALID <= !is_write && state_r == fbc_pkg::FBC_STROBE && tdone;
      if (!is_write && state_r == fbc_pkg::FBC_STROBE && tdone)
        RSP_RDATA <= BYTE_MODE ? {8'h00, FL_DQ_I[7:0]} : FL_DQ_I;
      RSP_DONE <= is_write && state_r == fbc_pkg::FBC_HOLD && tdone;
      FLASH_BUSY <= ~FL_READY_BUSY_N;
    end
  end

endmodule

// file: rtl/fbc_pkg.sv
package fbc_pkg;

  // Bus widths.
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;

  // Bus phase timing, in ns as figures and in cycles at the clock rate.
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_ACC_NS = 60;
  localparam int T_CE_NS = 60;
  localparam int T_WP_NS = 60;
  localparam int T_SETUP_NS = 25;
  localparam int T_HOLD_NS = 25;
  localparam int T_RH_NS = 50;
  localparam int T_RP_NS = 500;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CE_CYC = (T_CE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RH_CYC = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // Status bit positions on the data bus.
  localparam int POLL_BIT = 7;
  localparam int TOGGLE1_BIT = 6;
  localparam int TOGGLE2_BIT = 2;

  // Command codes of the host request port.
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_RESET = 2'h2;
  localparam logic [1:0] OP_POLL = 2'h3;

  // Sequencer states, Gray along idle-setup-strobe-hold.
  typedef enum logic [2:0] {
    FBC_IDLE = 3'h0,
    FBC_SETUP = 3'h1,
    FBC_STROBE = 3'h3,
    FBC_HOLD = 3'h2,
    FBC_RESET = 3'h6,
    FBC_RECOVER = 3'h7
  } fbc_state_t;

endpackage

// file: rtl/fbc_timer.sv
`timescale 1ns/1ps
module fbc_timer #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Load and status.
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);

  logic [W-1:0] cnt_r;

  assign done = (cnt_r == {W{1'b0}});

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_r <= {W{1'b0}};
    else if (load)
      cnt_r <= count;
    else if (!done)
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
  end

endmodule

// file: tb/fbc_ctrl_props.sv
`timescale 1ns/1ps
module fbc_ctrl_props (
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // Host port.
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic [1:0] REQ_OP,
  input wire logic RSP_VALID,
  input wire logic RSP_DONE,
  // Flash pins.
  input wire logic FL_CE_N,
  input wire logic FL_OE_N,
  input wire logic FL_WE_N,
  input wire logic FL_RESET_N,
  input wire logic FL_BYTE_N,
  input wire logic [15:0] FL_DQ_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_take;
    REQ_VALID && REQ_READY;
  endsequence
  sequence s_rd_take;
    s_take ##0 (REQ_OP == fbc_pkg::OP_READ || REQ_OP == fbc_pkg::OP_POLL);
  endsequence
  sequence s_wr_take;
    s_take ##0 REQ_OP == fbc_pkg::OP_WRITE;
  endsequence
  property p_rd;
    !FL_OE_N |-> !FL_CE_N && FL_WE_N && FL_DQ_OE[14:0] == 15'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("bad read pins");
  property p_wr;
    !FL_WE_N |-> !FL_CE_N && FL_OE_N;
  endproperty
  a_wr: assert property (p_wr) else $error("bad write pins");
  property p_hz;
    !FL_BYTE_N |-> FL_DQ_OE[14:8] == 7'h0;
  endproperty
  a_hz: assert property (p_hz) else $error("upper byte driven");
  property p_rdrsp;
    s_rd_take |-> ##7 RSP_VALID;
  endproperty
  a_rdrsp: assert property (p_rdrsp) else $error("no read data");
  property p_wrdone;
    s_wr_take |-> ##9 RSP_DONE;
  endproperty
  a_wrdone: assert property (p_wrdone) else $error("no write end");
  property p_acc;
    RSP_VALID |-> !$past(FL_CE_N, 3) && !$past(FL_OE_N);
  endproperty
  a_acc: assert property (p_acc) else $error("access too short");
  property p_rst;
    !FL_RESET_N |-> FL_CE_N && FL_WE_N && FL_OE_N;
  endproperty
  a_rst: assert property (p_rst) else $error("strobe in reset");
  property p_idle;
    REQ_READY |-> FL_CE_N && FL_OE_N && FL_WE_N;
  endproperty
  a_idle: assert property (p_idle) else $error("idle not standby");
endmodule
bind fbc_ctrl fbc_ctrl_props i_props (.*);

// file: tb/fbc_flash_model.sv
`timescale 1ns/1ps
module fbc_flash_model (
  // Control pins.
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rst_n,
  input wire logic byte_n,
  // Address and data.
  input wire logic [21:0] addr,
  input wire logic [15:0] dq,
  output logic [15:0] q,
  // Status.
  output logic rdy_n
);
  logic [15:0] mem [256];
  logic [15:0] last = 16'h0;
  logic [7:0] a;
  logic rd;
  assign a = addr[7:0];
  assign rd = !ce_n && !oe_n && we_n && rst_n;
  initial
  begin
    rdy_n = 1'b1;
    for (int i = 0; i < 256; i++) mem[i] = {8'(i), ~8'(i)};
  end
  // Writes land on the rising strobe, so data is taken at the early rise.
  always @(posedge we_n)
    if (!ce_n && oe_n && rst_n)
    begin
      if (byte_n) mem[a] = dq;
      else if (dq[15]) mem[a][15:8] = dq[7:0];
      else mem[a][7:0] = dq[7:0];
      rdy_n = 1'b0;
    end
  always @(negedge rdy_n) #150 rdy_n = 1'b1;
  always @(posedge oe_n) last = q;
  // Released lines show the inverse of the last value, never a stale copy.
  always @*
    if (rd && byte_n) q = mem[a];
    else if (rd) q = {~last[15:8], dq[15] ? mem[a][15:8] : mem[a][7:0]};
    else q = ~last;
endmodule

// file: tb/flash_bus_operation_control_bench.sv
`timescale 1ns/1ps
module flash_bus_operation_control_bench;
  logic CLK = 1'b0, SYS_RST = 1'b1, REQ_VALID = 1'b0, REQ_LSB = 1'b0;
  logic BYTE_MODE = 1'b0, WRITE_PROTECT = 1'b0;
  logic [1:0] REQ_OP = 2'h0;
  logic [21:0] REQ_ADDR = 22'h0, FL_ADDR, a;
  logic [15:0] REQ_WDATA = 16'h0, RSP_RDATA, FL_DQ_I, FL_DQ_O, FL_DQ_OE, mdl_q, d;
  logic REQ_READY, RSP_VALID, RSP_DONE, FLASH_BUSY, FL_CE_N, FL_OE_N, FL_WE_N;
  logic FL_RESET_N, FL_WP_N, FL_BYTE_N, FL_READY_BUSY_N;
  logic [15:0] ref_mem [256];
  int failures = 0, n_checks = 0;
  fbc_ctrl #(.RP_CYCLES(8'h02)) i_dut (.*);
  fbc_flash_model i_flash (.ce_n(FL_CE_N), .oe_n(FL_OE_N), .we_n(FL_WE_N),
    .rst_n(FL_RESET_N), .byte_n(FL_BYTE_N), .addr(FL_ADDR), .dq(FL_DQ_I),
    .q(mdl_q), .rdy_n(FL_READY_BUSY_N));
  assign FL_DQ_I = (FL_DQ_OE & FL_DQ_O) | (~FL_DQ_OE & mdl_q);
  initial forever #12.5 CLK = ~CLK;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic req(input logic [1:0] op, input logic l);
    int n;
    n = 0;
    REQ_VALID <= 1'b1;
    REQ_OP <= op;
    REQ_ADDR <= a;
    REQ_LSB <= l;
    REQ_WDATA <= d;
    do @(posedge CLK); while (REQ_READY !== 1'b1 && ++n < 300);
    REQ_VALID <= 1'b0;
    while (op != fbc_pkg::OP_RESET && RSP_VALID !== 1'b1 && RSP_DONE !== 1'b1 && ++n < 300)
      @(posedge CLK);
    if (n >= 300) failures++;
  endtask
  function automatic logic [15:0] exp_rd(input logic l);
    if (!BYTE_MODE) return ref_mem[a[7:0]];
    return {8'h00, l ? ref_mem[a[7:0]][15:8] : ref_mem[a[7:0]][7:0]};
  endfunction
  task automatic wr(input logic l);
    req(fbc_pkg::OP_WRITE, l);
    if (!BYTE_MODE) ref_mem[a[7:0]] = d;
    else if (l) ref_mem[a[7:0]][15:8] = d[7:0];
    else ref_mem[a[7:0]][7:0] = d[7:0];
    @(posedge CLK);
    chk(16'(FLASH_BUSY), 16'h1);
  endtask
  task automatic rd(input logic [1:0] op, input logic l);
    req(op, l);
    chk(RSP_RDATA, exp_rd(l));
  endtask
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    failures++;
    print_verdict();
  end
  initial
  begin
    for (int i = 0; i < 256; i++) ref_mem[i] = {8'(i), ~8'(i)};
    void'($urandom(32'h5f00));
    repeat (4) @(posedge CLK);
    SYS_RST <= 1'b0;
    repeat (3) @(posedge CLK);
    chk(16'(FL_CE_N), 16'h1);
    for (int i = 0; i < 20; i++)
    begin
      if (i == 12) BYTE_MODE <= 1'b1;
      if (i == 12) @(posedge CLK);
      a = 22'($urandom);
      d = 16'($urandom);
      if (i > 3) wr(i[0]);
      rd(i[1] ? fbc_pkg::OP_POLL : fbc_pkg::OP_READ, i[0]);
      if (BYTE_MODE) rd(fbc_pkg::OP_READ, !i[0]);
      if (BYTE_MODE) chk(16'(FL_BYTE_N), 16'h0);
    end
    WRITE_PROTECT <= 1'b1;
    repeat (2) @(posedge CLK);
    chk(16'(FL_WP_N), 16'h0);
    WRITE_PROTECT <= 1'b0;
    BYTE_MODE <= 1'b0;
    req(fbc_pkg::OP_RESET, 1'b0);
    rd(fbc_pkg::OP_READ, 1'b0);
    print_verdict();
  end
endmodule
